/* verilog/bpl_pkg.sv */
// package: register offsets, reset values and carrier types for the byte port block
package bpl_pkg;
  // ------------------------------------------------------------
  // register page and offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PAGE_HIGH = 8'h0f;
  localparam logic [7:0] OFS_P3_LATCH = 8'hb0;
  localparam logic [7:0] OFS_P4_LATCH = 8'hc8;
  localparam logic [7:0] OFS_P5_LATCH = 8'hd8;
  localparam logic [7:0] OFS_P6_LATCH = 8'he8;
  localparam logic [7:0] OFS_P7_LATCH = 8'hf8;
  localparam logic [7:0] OFS_P3_MODE = 8'ha7;
  localparam logic [7:0] OFS_P4_MODE = 8'h9c;
  localparam logic [7:0] OFS_P5_MODE = 8'h9d;
  localparam logic [7:0] OFS_P6_MODE = 8'h9e;
  localparam logic [7:0] OFS_P7_MODE = 8'h9f;
  // ------------------------------------------------------------
  // reset values and field masks
  // ------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] P4_PIN_MASK = 8'he0;
  localparam int NUM_PORTS = 5;
  localparam int P4_IDX = 1;
  localparam int P5_IDX = 2;
  localparam int P6_IDX = 3;
  localparam int P7_IDX = 4;
  localparam int P4_WR_BIT = 7;
  localparam int P4_RD_BIT = 6;
  localparam int P4_ALE_BIT = 5;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } bpl_bus_s;

  typedef struct packed {
    logic active;
    logic is_read;
    logic muxed;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr_strobe_n;
    logic rd_strobe_n;
    logic ale;
  } bpl_external_memory_interface_s;
endpackage

/* verilog/bpl_port.sv */
// module: latch, drive mode, pull-up and pin logic for the third to seventh ports
`timescale 1ns/1ps
// Overview of operation
// [RL1] latch 0 drives low; latch 1 drives high only with push-pull, else released
// [RL2] normal port read returns synchronised live pin levels
// [RL3] read phase of read-modify-write returns stored latch contents
// [RL4] push-pull drives low for 0 and high for 1
// [RL5] open-drain drives low for 0 and floats for 1
// [RL6] drive-mode bit 0 open-drain, 1 push-pull; all clear on reset
// [RL7] software makes an input by open-drain plus latch 1
// [RL8] pull-ups on by default; global disable turns all off
// [RL9] pull-up off on any pin being driven low
// [RL10] external memory interface overrides latches on high ports during moves
// [RL11] drive modes unchanged by interface; reads release the data bus
// [RL12] fourth port has bits 7..5 only; low bits fixed by software
// [RL13] high port registers need register page 0x0f selected
// [RL14] registers and input paths work even without pins
// [RL15] interface may drive write, read and latch strobes on fourth port
// [RL16] address high and low on fifth and sixth ports, per mux mode
// [RL17] software should keep unpinned inputs from floating
module bpl_port
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bpl_pkg::bpl_bus_s bus,
  output logic [7:0] rdata,
  output logic rdata_hit,
  input wire logic global_pullup_disable,
  input wire logic external_memory_interface_on_high_ports,
  input wire bpl_pkg::bpl_external_memory_interface_s external_memory_interface,
  input wire logic [39:0] pin_in,
  output logic [39:0] pin_out,
  output logic [39:0] pin_oe,
  output logic [39:0] pin_pullup_en
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] latch [bpl_pkg::NUM_PORTS];
  logic [7:0] next_latch [bpl_pkg::NUM_PORTS];
  logic [7:0] mode [bpl_pkg::NUM_PORTS];
  logic [7:0] next_mode [bpl_pkg::NUM_PORTS];
  logic [39:0] pin_meta;
  logic [39:0] pin_sync;
  logic [7:0] next_rdata;
  logic next_rdata_hit;
  logic [7:0] lat_ofs [bpl_pkg::NUM_PORTS];
  logic [7:0] mod_ofs [bpl_pkg::NUM_PORTS];
  logic [39:0] drv_val;
  logic [39:0] drv_pp;
  logic [39:0] external_memory_interface_own;
  logic [39:0] external_memory_interface_val;
  logic [39:0] external_memory_interface_release;
  logic [39:0] eff_out;
  logic [39:0] eff_oe;
  logic page_ok [bpl_pkg::NUM_PORTS];
  logic lat_sel [bpl_pkg::NUM_PORTS];
  logic mod_sel [bpl_pkg::NUM_PORTS];
  logic [7:0] lat_rd [bpl_pkg::NUM_PORTS];
  logic [39:0] next_pin_meta;
  logic [39:0] next_pin_sync;
  logic dbus_own;
  logic [7:0] dbus_val;
  logic dbus_release;

  assign lat_ofs[0] = bpl_pkg::OFS_P3_LATCH;
  assign lat_ofs[1] = bpl_pkg::OFS_P4_LATCH;
  assign lat_ofs[2] = bpl_pkg::OFS_P5_LATCH;
  assign lat_ofs[3] = bpl_pkg::OFS_P6_LATCH;
  assign lat_ofs[4] = bpl_pkg::OFS_P7_LATCH;
  assign mod_ofs[0] = bpl_pkg::OFS_P3_MODE;
  assign mod_ofs[1] = bpl_pkg::OFS_P4_MODE;
  assign mod_ofs[2] = bpl_pkg::OFS_P5_MODE;
  assign mod_ofs[3] = bpl_pkg::OFS_P6_MODE;
  assign mod_ofs[4] = bpl_pkg::OFS_P7_MODE;

  // ------------------------------------------------------------
  // address decode and read-back source, per port
  // ------------------------------------------------------------
  // decoded once so the write and read paths cannot disagree on a hit
  genvar gd;
  generate
    for (gd = 0; gd < bpl_pkg::NUM_PORTS; gd++)
    begin : g_dec
      // the third port latch is visible on every page; the rest need the high page
      assign page_ok[gd] = (gd == 0) ? 1'b1 : (bus.page == bpl_pkg::PAGE_HIGH); // RL13
      assign lat_sel[gd] = (bus.addr == lat_ofs[gd]) && page_ok[gd];
      // drive-mode registers, the third port's too, sit on the high page only
      assign mod_sel[gd] = (bus.addr == mod_ofs[gd]) && (bus.page == bpl_pkg::PAGE_HIGH);

      always_comb
      begin
        if (bus.rmw)
        begin
          lat_rd[gd] = latch[gd]; // RL3
        end
        else if (gd == bpl_pkg::P4_IDX)
        begin
          // unimplemented low pins read as ones, matching what software writes
          lat_rd[gd] = pin_sync[gd*8 +: 8] | ~bpl_pkg::P4_PIN_MASK; // RL12
        end
        else
        begin
          lat_rd[gd] = pin_sync[gd*8 +: 8]; // RL2
        end
      end

      assign drv_val[gd*8 +: 8] = latch[gd];
      assign drv_pp[gd*8 +: 8] = mode[gd];
    end
  endgenerate

  // ------------------------------------------------------------
  // register writes, per port
  // ------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < bpl_pkg::NUM_PORTS; gp++)
    begin : g_reg
      always_comb
      begin
        next_latch[gp] = latch[gp];
        next_mode[gp] = mode[gp];
        if (bus.wr && lat_sel[gp])
        begin
          next_latch[gp] = bus.wdata; // RL1
        end
        if (bus.wr && mod_sel[gp])
        begin
          next_mode[gp] = bus.wdata; // RL6
        end
      end

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          latch[gp] <= bpl_pkg::LATCH_RESET;
          mode[gp] <= bpl_pkg::MODE_RESET; // RL6
        end
        // frozen while clk_en is low, so a held request does not land
        else if (clk_en)
        begin
          latch[gp] <= next_latch[gp];
          mode[gp] <= next_mode[gp];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  // input paths stay live even on unpinned ports
  always_comb
  begin
    next_pin_meta = pin_in;
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge sys_clk)
  begin
    // cleared, so pins read low until two edges after release
    if (rst)
    begin
      pin_meta <= 40'h0;
      pin_sync <= 40'h0;
    end
    else if (clk_en)
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync; // RL14
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    next_rdata_hit = 1'b0;
    for (int i = 0; i < bpl_pkg::NUM_PORTS; i++)
    begin
      if (bus.rd && lat_sel[i])
      begin
        next_rdata_hit = 1'b1;
        next_rdata = lat_rd[i];
      end
      if (bus.rd && mod_sel[i])
      begin
        next_rdata_hit = 1'b1;
        next_rdata = mode[i];
      end
    end
  end

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  // unmapped reads return zero with the hit flag low
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      rdata_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata <= next_rdata;
      rdata_hit <= next_rdata_hit;
    end
  end

  // ------------------------------------------------------------
  // external memory interface override
  // ------------------------------------------------------------
  always_comb
  begin
    external_memory_interface_own = 40'h0;
    external_memory_interface_val = 40'h0;
    external_memory_interface_release = 40'h0;
    if (external_memory_interface_on_high_ports && external_memory_interface.active)
    begin
      external_memory_interface_own[bpl_pkg::P4_IDX*8+bpl_pkg::P4_WR_BIT] = 1'b1; // RL15
      external_memory_interface_own[bpl_pkg::P4_IDX*8+bpl_pkg::P4_RD_BIT] = 1'b1;
      external_memory_interface_own[bpl_pkg::P4_IDX*8+bpl_pkg::P4_ALE_BIT] = 1'b1;
      external_memory_interface_val[bpl_pkg::P4_IDX*8+bpl_pkg::P4_WR_BIT] = external_memory_interface.wr_strobe_n;
      external_memory_interface_val[bpl_pkg::P4_IDX*8+bpl_pkg::P4_RD_BIT] = external_memory_interface.rd_strobe_n;
      external_memory_interface_val[bpl_pkg::P4_IDX*8+bpl_pkg::P4_ALE_BIT] = external_memory_interface.ale;
      external_memory_interface_own[bpl_pkg::P6_IDX*8 +: 8] = 8'hff; // RL16
      if (external_memory_interface.muxed)
      begin
        external_memory_interface_val[bpl_pkg::P6_IDX*8 +: 8] = external_memory_interface.addr[15:8]; // RL16
      end
      else
      begin
        external_memory_interface_own[bpl_pkg::P5_IDX*8 +: 8] = 8'hff;
        external_memory_interface_val[bpl_pkg::P5_IDX*8 +: 8] = external_memory_interface.addr[15:8]; // RL16
        external_memory_interface_val[bpl_pkg::P6_IDX*8 +: 8] = external_memory_interface.addr[7:0];
      end
    end
    external_memory_interface_own[bpl_pkg::P7_IDX*8 +: 8] = {8{dbus_own}}; // RL10
    external_memory_interface_val[bpl_pkg::P7_IDX*8 +: 8] = dbus_val;
    external_memory_interface_release[bpl_pkg::P7_IDX*8 +: 8] = {8{dbus_release}};
  end

  // ------------------------------------------------------------
  // external memory interface data bus on the seventh port
  // ------------------------------------------------------------
  always_comb
  begin
    dbus_own = 1'b0;
    dbus_val = 8'h00;
    dbus_release = 1'b0;
    if (external_memory_interface_on_high_ports && external_memory_interface.active)
    begin
      dbus_own = 1'b1; // RL10
      // muxed bus carries the low address while the latch strobe is high
      if (external_memory_interface.muxed && external_memory_interface.ale)
      begin
        dbus_val = external_memory_interface.addr[7:0];
      end
      else
      begin
        dbus_val = external_memory_interface.wdata;
        // a read hands the data bus to the outside device
        dbus_release = external_memory_interface.is_read; // RL11
      end
    end
  end

  // ------------------------------------------------------------
  // pin drivers and pull-ups
  // ------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 40; gb++)
    begin : g_pin
      // the interface replaces the latch value only on pins it owns
      assign eff_out[gb] = external_memory_interface_own[gb] ? external_memory_interface_val[gb] : drv_val[gb]; // RL10

      if (gb >= bpl_pkg::P4_IDX*8 && gb < bpl_pkg::P4_IDX*8 + 5)
      begin : g_absent
        // no pad behind these bits, so never drive them
        assign eff_oe[gb] = 1'b0; // RL12
      end
      else
      begin : g_present
        // mode register still decides the high level; only a read releases
        assign eff_oe[gb] = (~eff_out[gb] | drv_pp[gb]) & ~external_memory_interface_release[gb]; // RL1 RL4 RL5 RL11
      end

      assign pin_out[gb] = eff_out[gb] & eff_oe[gb];
      assign pin_oe[gb] = eff_oe[gb];
      // pull-up released when pin driven low, so output never fights it
      assign pin_pullup_en[gb] = ~global_pullup_disable & ~(eff_oe[gb] & ~eff_out[gb]); // RL8 RL9
    end
  endgenerate
endmodule

/* test/bpl_checker.sv */
// checker: bus, pin and override relations of the byte ports
`timescale 1ns/1ps
module bpl_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bpl_pkg::bpl_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic rdata_hit,
  input wire logic global_pullup_disable,
  input wire logic external_memory_interface_on_high_ports,
  input wire bpl_pkg::bpl_external_memory_interface_s external_memory_interface,
  input wire logic [39:0] pin_in,
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] pin_pullup_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic ov = external_memory_interface_on_high_ports && external_memory_interface.active;
  // a driven pin shows v; a 0 in v must be driven
  function automatic logic bad(logic [7:0] o, d, v);
    return |((o & (d ^ v)) | (~o & ~v));
  endfunction
  sequence s_p3_wr;
    clk_en && bus.wr && bus.addr == 8'hb0;
  endsequence
  a_low_drive: assert property (s_p3_wr |=> !bad(pin_oe[7:0], pin_out[7:0], $past(bus.wdata)))
    else $error("latch not on pins");
  a_no_fight: assert property (!(|(pin_oe & ~pin_out & pin_pullup_en)))
    else $error("pull-up on low pin");
  a_pull_off: assert property (global_pullup_disable |-> pin_pullup_en == 40'h0)
    else $error("pull-up not disabled");
  a_rst_state: assert property ($fell(rst) && !ov |-> pin_oe == 40'h0)
    else $error("pin driven after reset");
  a_external_memory_interface_addr: assert property (ov && !external_memory_interface.muxed |-> !bad(pin_oe[23:16], pin_out[23:16], external_memory_interface.addr[15:8]))
    else $error("address high wrong");
  a_external_memory_interface_mux: assert property (ov && external_memory_interface.muxed |-> !bad(pin_oe[31:24], pin_out[31:24], external_memory_interface.addr[15:8]))
    else $error("muxed address wrong");
  a_strobe_pins: assert property (ov |-> !bad({pin_oe[15:13], 5'h1f}, {pin_out[15:13], 5'h00},
    {external_memory_interface.wr_strobe_n, external_memory_interface.rd_strobe_n, external_memory_interface.ale, 5'h00}))
    else $error("strobe pins wrong");
  a_read_float: assert property (ov && external_memory_interface.is_read && !external_memory_interface.muxed |-> pin_oe[39:32] == 8'h00)
    else $error("data bus driven in read");
endmodule
bind bpl_port bpl_checker u_chk (.sys_clk, .rst, .clk_en, .bus, .rdata, .rdata_hit,
  .global_pullup_disable, .external_memory_interface_on_high_ports, .external_memory_interface, .pin_in, .pin_out, .pin_oe, .pin_pullup_en);

/* test/bpl_pins.sv */
// partner: pad ring with outside drivers and weak pull-ups
`timescale 1ns/1ps
module bpl_pins
(
  input wire logic sys_clk,
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] pin_pullup_en,
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_val,
  output logic [39:0] pin_in
);
  logic [39:0] last = 40'h0;
  // floating pin without pull-up wanders, never holds its old level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup_en | ~last));
  always @(posedge sys_clk)
  begin
    last <= pin_in;
  end
endmodule

/* test/tb_top.sv */
// testbench: byte port latches, drive modes, pin reads and override
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) fails++; \
    if ((g) !== (e)) $display("MISMATCH %0t %h %h", $time, g, e); \
  end
module tb_top;
  logic sys_clk = 0, rst = 1, clk_en = 1, gpd = 0, eon = 0, rdata_hit;
  bpl_pkg::bpl_bus_s bus = '0;
  bpl_pkg::bpl_external_memory_interface_s external_memory_interface = '0;
  logic [7:0] rdata;
  logic [39:0] ext_en = 40'h0, ext_val = 40'h0, pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [7:0] lo[5] = '{8'hb0, 8'hc8, 8'hd8, 8'he8, 8'hf8};
  logic [7:0] mo[5] = '{8'ha7, 8'h9c, 8'h9d, 8'h9e, 8'h9f};
  int fails = 0, check_count = 0;
  always #2 sys_clk = ~sys_clk;
  bpl_port uut (.sys_clk, .rst, .clk_en, .bus, .rdata, .rdata_hit, .global_pullup_disable(gpd),
    .external_memory_interface_on_high_ports(eon), .external_memory_interface, .pin_in, .pin_out, .pin_oe, .pin_pullup_en);
  bpl_pins pins (.sys_clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in);
  task automatic acc(input logic w, r, m, input logic [7:0] a, p, d);
    @(posedge sys_clk);
    bus <= '{w, r, m, a, p, d};
    @(posedge sys_clk);
    bus <= '0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1, 0, 0, a, 8'h0f, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    acc(0, 1, m, a, 8'h0f, 8'h00);
    `CHK({rdata_hit, rdata}, {1'b1, e})
  endtask
  task automatic t_reset;
    `CHK(pin_oe, 40'h0)
    `CHK(pin_pullup_en, 40'hffffffffff)
    foreach (mo[i]) rd(mo[i], 0, 8'h00);
    foreach (lo[i]) rd(lo[i], 1, 8'hff);
    acc(0, 1, 0, 8'h80, 8'h0f, 8'h00);
    `CHK({rdata_hit, rdata}, 9'h000)
  endtask
  task automatic t_drive;
    acc(1, 0, 0, 8'hb0, 8'h00, 8'h0f);
    `CHK({pin_oe[7:0], pin_out[7:0]}, 16'hf000)
    `CHK(pin_pullup_en[7:0], 8'h0f)
    wr(8'ha7, 8'hff);
    `CHK({pin_oe[7:0], pin_out[7:0]}, 16'hff0f)
    wr(8'ha7, 8'h00);
    wr(8'hb0, 8'hff);
    acc(1, 0, 0, 8'hd8, 8'h00, 8'h00);
    `CHK(pin_oe[23:16], 8'h00)
    wr(8'hc8, 8'h00);
    `CHK({pin_oe[15:8], pin_out[15:8]}, 16'he000)
    wr(8'hc8, 8'hff);
  endtask
  task automatic t_input;
    @(posedge sys_clk);
    ext_en <= 40'hff0000e000;
    ext_val <= 40'h5a00004000;
    repeat (3) @(posedge sys_clk);
    rd(8'hf8, 0, 8'h5a);
    rd(8'hf8, 1, 8'hff);
    rd(8'hc8, 0, 8'h5f);
    @(posedge sys_clk);
    gpd <= 1;
    #1 `CHK(pin_pullup_en, 40'h0)
  endtask
  task automatic t_external_memory_interface;
    foreach (mo[i]) wr(mo[i], i == 1 ? 8'he0 : 8'hff);
    @(posedge sys_clk);
    ext_en <= 40'h0;
    eon <= 1;
    external_memory_interface <= '{1, 0, 0, 16'h1234, 8'h5a, 0, 1, 0};
    #1 `CHK(pin_out[39:13], {24'h5a3412, 3'b010})
    @(posedge sys_clk);
    external_memory_interface <= '{1, 1, 0, 16'h1234, 8'h5a, 1, 0, 0};
    #1 `CHK(pin_oe[39:32], 8'h00)
    @(posedge sys_clk);
    external_memory_interface <= '{1, 0, 1, 16'h1234, 8'h5a, 1, 1, 1};
    #1 `CHK(pin_out[39:24], 16'h3412)
    rd(8'h9f, 0, 8'hff);
    @(posedge sys_clk);
    external_memory_interface <= '0;
    #1 `CHK(pin_out[39:16], 24'hffffff)
  endtask
  task automatic t_float;
    @(posedge sys_clk);
    gpd <= 0;
    wr(8'hf8, 8'h00);
    `CHK({pin_oe[39:32], pin_out[39:32], pin_pullup_en[39:32]}, 24'hff0000)
    @(posedge sys_clk);
    clk_en <= 0;
    wr(8'hf8, 8'hff);
    `CHK(pin_out[39:32], 8'h00)
    @(posedge sys_clk);
    clk_en <= 1;
    rst <= 1;
    @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    #1 `CHK({pin_oe, rdata_hit}, 41'h0)
  endtask
  task automatic give_verdict;
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    #1;
    t_reset;
    t_drive;
    t_input;
    t_external_memory_interface;
    t_float;
    give_verdict;
  end
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    #10000;
    fails++;
    give_verdict;
  end
endmodule
